/* File: logic/flash_host.v */
// apb-controlled host that issues command sequences to a byte-wide nor flash
// assumes a single pclk domain; flash inputs are synchronous to pclk
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"

module flash_host #(
  parameter ADDR_W = 19
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output reg               pslverr,
  output wire [ADDR_W-1:0] flash_addr,
  output wire [7:0]        flash_dq_out,
  output wire              flash_dq_oe,
  input  wire [7:0]        flash_dq_in,
  output wire              flash_ce_n,
  output wire              flash_oe_n,
  output wire              flash_we_n,
  output wire              flash_reset_n,
  input  wire              operation_done_n
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_WRITE = 3'h1;
  localparam [2:0] S_WWAIT = 3'h2;
  localparam [2:0] S_READ  = 3'h3;
  localparam [2:0] S_RWAIT = 3'h4;
  localparam [2:0] S_POLL  = 3'h5;
  localparam [2:0] S_PWAIT = 3'h6;

  // number of command writes for each operation
  function [2:0] write_count;
    input [3:0] op;
    begin
      case (op)
        `OP_READ:       write_count = 3'd0;
        `OP_PROGRAM:    write_count = 3'd4;
        `OP_CHIP_ERASE: write_count = 3'd6;
        `OP_SECT_ERASE: write_count = 3'd6;
        `OP_IDENT:      write_count = 3'd3;
        default:        write_count = 3'd1;
      endcase
    end
  endfunction

  // address selector and data byte of write step 'step' of operation 'op'
  function [9:0] seq_word;
    input [3:0] op;
    input [2:0] step;
    begin
      case (step)
        3'd0:    seq_word = {`SEL_UNLOCK1, `DATA_UNLOCK1};
        3'd1:    seq_word = {`SEL_UNLOCK2, `DATA_UNLOCK2};
        3'd2:    seq_word = {`SEL_UNLOCK1, `CMD_ERASE_SETUP};
        3'd3:    seq_word = {`SEL_UNLOCK1, `DATA_UNLOCK1};
        3'd4:    seq_word = {`SEL_UNLOCK2, `DATA_UNLOCK2};
        default: seq_word = {`SEL_UNLOCK1, `CMD_CHIP_ERASE};
      endcase
      case (op)
        `OP_RESET:   seq_word = {`SEL_TARGET, `CMD_RESET};
        `OP_SUSPEND: seq_word = {`SEL_TARGET, `CMD_SUSPEND};
        `OP_RESUME:  seq_word = {`SEL_TARGET, `CMD_RESUME};
        `OP_QUERY:   seq_word = {`SEL_QUERY, `CMD_QUERY};
        `OP_IDENT: begin
          if (step == 3'd2)
            seq_word = {`SEL_UNLOCK1, `CMD_IDENT};
        end
        `OP_PROGRAM: begin
          if (step == 3'd2)
            seq_word = {`SEL_UNLOCK1, `CMD_PROGRAM};
          else if (step == 3'd3)
            seq_word = {`SEL_TARGET, 8'h00};
        end
        `OP_SECT_ERASE: begin
          if (step == 3'd5)
            seq_word = {`SEL_TARGET, `CMD_SECT_ERASE};
        end
        default: begin
        end
      endcase
    end
  endfunction

  reg [2:0]        state;
  reg [3:0]        op;
  reg [2:0]        step;
  reg [ADDR_W-1:0] target;
  reg [7:0]        wbyte;
  reg [7:0]        rbyte;
  reg              hold_reset;
  reg              done_flag;
  reg              fail_flag;
  reg              refused_flag;
  reg              have_prev;
  reg [7:0]        prev_byte;
  reg [31:0]       next_prdata;

  wire             cyc_done;
  wire [7:0]       cyc_rdata;
  wire [9:0]       word;
  reg  [ADDR_W-1:0] cyc_addr;
  reg  [7:0]       cyc_wdata;

  wire busy      = (state != S_IDLE);
  wire apb_write = psel & penable & pwrite;
  wire cmd_write = apb_write & (paddr == `REG_CMD);
  wire cyc_start = (state == S_WRITE) | (state == S_READ) | (state == S_POLL);
  wire wants_read = (op == `OP_READ) | (op == `OP_IDENT) | (op == `OP_QUERY);
  wire wants_poll = (op == `OP_PROGRAM) | (op == `OP_CHIP_ERASE) |
                    (op == `OP_SECT_ERASE) | (op == `OP_RESUME);

  assign word          = seq_word(op, step);
  assign pready        = 1'b1;
  assign flash_reset_n = ~hold_reset;

  // unlock addresses carry zeros above bit 11, the query address above bit 7; target commands use target
  always @* begin
    case (word[9:8])
      `SEL_UNLOCK1: cyc_addr = {{(ADDR_W-12){1'b0}}, `ADDR_UNLOCK1};
      `SEL_UNLOCK2: cyc_addr = {{(ADDR_W-12){1'b0}}, `ADDR_UNLOCK2};
      `SEL_QUERY:   cyc_addr = {{(ADDR_W-8){1'b0}}, `ADDR_QUERY};
      default:      cyc_addr = target;
    endcase
    cyc_wdata = word[7:0];
    if (op == `OP_PROGRAM && step == 3'd3)
      cyc_wdata = wbyte;
  end

  flash_bus_cycle #(
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (cyc_start),
    .write        (state == S_WRITE),
    .addr         (state == S_WRITE ? cyc_addr : target),
    .wdata        (cyc_wdata),
    .done         (cyc_done),
    .rdata        (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= S_IDLE;
      op           <= `OP_RESET;
      step         <= 3'd0;
      target       <= {ADDR_W{1'b0}};
      wbyte        <= 8'h00;
      rbyte        <= 8'h00;
      hold_reset   <= 1'b0;
      done_flag    <= 1'b0;
      fail_flag    <= 1'b0;
      refused_flag <= 1'b0;
      have_prev    <= 1'b0;
      prev_byte    <= 8'h00;
    end else begin
      if (apb_write && paddr == `REG_ADDR && !busy)
        target <= pwdata[ADDR_W-1:0];
      if (apb_write && paddr == `REG_WDATA && !busy)
        wbyte <= pwdata[7:0];
      if (apb_write && paddr == `REG_CTRL)
        hold_reset <= pwdata[`CTRL_HOLD_RESET];
      if (apb_write && paddr == `REG_STATUS && pwdata[`ST_REFUSED])
        refused_flag <= 1'b0;
      // a new order while a sequence or polling runs is refused
      if (cmd_write && (busy || hold_reset))
        refused_flag <= 1'b1;
      case (state)
        S_IDLE: begin
          if (cmd_write && !hold_reset) begin
            op        <= pwdata[3:0];
            step      <= 3'd0;
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
            have_prev <= 1'b0;
            state     <= (pwdata[3:0] == `OP_READ) ? S_READ : S_WRITE;
          end
        end
        S_WRITE: state <= S_WWAIT;
        S_WWAIT: begin
          if (cyc_done) begin
            step <= step + 3'd1;
            if (step + 3'd1 != write_count(op))
              state <= S_WRITE;
            else if (wants_read)
              state <= S_READ;
            else if (wants_poll)
              state <= S_POLL;
            else begin
              done_flag <= 1'b1;
              state     <= S_IDLE;
            end
          end
        end
        S_READ: state <= S_RWAIT;
        S_RWAIT: begin
          if (cyc_done) begin
            rbyte     <= cyc_rdata;
            done_flag <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_POLL: state <= S_PWAIT;
        S_PWAIT: begin
          if (cyc_done) begin
            rbyte     <= cyc_rdata;
            prev_byte <= cyc_rdata;
            have_prev <= 1'b1;
            // toggle bit steady across two reads marks the end
            if (have_prev && prev_byte[`BIT_TOGGLE] == cyc_rdata[`BIT_TOGGLE]) begin
              done_flag <= 1'b1;
              state     <= S_IDLE;
            end else if (have_prev && cyc_rdata[`BIT_TIMEOUT]) begin
              fail_flag <= 1'b1;
              done_flag <= 1'b1;
              state     <= S_IDLE;
            end else begin
              state <= S_POLL;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    pslverr     = 1'b0;
    case (paddr)
      `REG_CMD:    next_prdata = {28'h000_0000, op};
      `REG_ADDR:   next_prdata = {{(32-ADDR_W){1'b0}}, target};
      `REG_WDATA:  next_prdata = {24'h00_0000, wbyte};
      `REG_CTRL:   next_prdata = {31'h0000_0000, hold_reset};
      `REG_RDATA:  next_prdata = {24'h00_0000, rbyte};
      `REG_STATUS: next_prdata = {27'h000_0000, refused_flag, operation_done_n, fail_flag, done_flag, busy};
      default:     pslverr     = psel & penable;
    endcase
  end

  // read word captured in the setup cycle, stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end

endmodule
`default_nettype wire

/* File: pkg/flash_host_defs.vh */
// constants of the parallel nor flash command host: register map, op codes,
// flash command bytes and strobe timing; assumes a 100 MHz pclk
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

`define REG_CMD         12'h000
`define REG_ADDR        12'h004
`define REG_WDATA       12'h008
`define REG_CTRL        12'h00C
`define REG_RDATA       12'h010
`define REG_STATUS      12'h014

`define ST_BUSY         0
`define ST_DONE         1
`define ST_FAIL         2
`define ST_READY_PIN    3
`define ST_REFUSED      4
`define CTRL_HOLD_RESET 0

`define OP_RESET        4'h0
`define OP_READ         4'h1
`define OP_PROGRAM      4'h2
`define OP_CHIP_ERASE   4'h3
`define OP_SECT_ERASE   4'h4
`define OP_SUSPEND      4'h5
`define OP_RESUME       4'h6
`define OP_IDENT        4'h7
`define OP_QUERY        4'h8

`define SEL_UNLOCK1     2'h0
`define SEL_UNLOCK2     2'h1
`define SEL_TARGET      2'h2
`define SEL_QUERY       2'h3

`define ADDR_UNLOCK1    12'h555
`define ADDR_UNLOCK2    12'h2AA
`define ADDR_QUERY      8'hAA
`define DATA_UNLOCK1    8'hAA
`define DATA_UNLOCK2    8'h55
`define CMD_PROGRAM     8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE  8'h10
`define CMD_SECT_ERASE  8'h30
`define CMD_RESUME      8'h30
`define CMD_SUSPEND     8'hB0
`define CMD_IDENT       8'h90
`define CMD_QUERY       8'h98
`define CMD_RESET       8'hF0

`define BIT_TOGGLE      6
`define BIT_TIMEOUT     5

`define CLK_MHZ         100
`define T_SETUP_NS      10
`define T_WRITE_NS      50
`define T_READ_NS       100
`define T_HOLD_NS       20

`endif

/* File: logic/flash_bus_cycle.v */
// one asynchronous flash bus cycle, read or write, with strobe timing
// assumes the caller holds nothing: address and data are latched at start
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"

module flash_bus_cycle #(
  parameter ADDR_W = 19
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              start,
  input  wire              write,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wdata,
  output reg               done,
  output reg  [7:0]        rdata,
  output reg  [ADDR_W-1:0] flash_addr,
  output reg  [7:0]        flash_dq_out,
  output reg               flash_dq_oe,
  input  wire [7:0]        flash_dq_in,
  output reg               flash_ce_n,
  output reg               flash_oe_n,
  output reg               flash_we_n
);

  function [7:0] cycles_up;
    input integer ns;
    integer c;
    begin
      c = (ns * `CLK_MHZ + 999) / 1000;
      if (c < 1)
        c = 1;
      cycles_up = c[7:0];
    end
  endfunction

  localparam [7:0] N_SETUP = cycles_up(`T_SETUP_NS);
  localparam [7:0] N_WRITE = cycles_up(`T_WRITE_NS);
  localparam [7:0] N_READ  = cycles_up(`T_READ_NS);
  localparam [7:0] N_HOLD  = cycles_up(`T_HOLD_NS);

  localparam [1:0] P_IDLE   = 2'h0;
  localparam [1:0] P_SETUP  = 2'h1;
  localparam [1:0] P_STROBE = 2'h2;
  localparam [1:0] P_HOLD   = 2'h3;

  reg [1:0] phase;
  reg [7:0] count;
  reg       is_write;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase        <= P_IDLE;
      count        <= 8'h00;
      is_write     <= 1'b0;
      done         <= 1'b0;
      rdata        <= 8'h00;
      flash_addr   <= {ADDR_W{1'b0}};
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
    end else begin
      done <= 1'b0;
      case (phase)
        P_IDLE: begin
          if (start) begin
            flash_addr   <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe  <= write;
            is_write     <= write;
            flash_ce_n   <= 1'b0;
            count        <= N_SETUP;
            phase        <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (count > 8'h01) begin
            count <= count - 8'h01;
          end else begin
            // write strobe falls on a write, output enable on a read, with address stable
            flash_we_n <= ~is_write;
            flash_oe_n <= is_write;
            count      <= is_write ? N_WRITE : N_READ;
            phase      <= P_STROBE;
          end
        end
        P_STROBE: begin
          if (count > 8'h01) begin
            count <= count - 8'h01;
          end else begin
            if (!is_write)
              rdata <= flash_dq_in;
            // data still driven while the strobe rises
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            count      <= N_HOLD;
            phase      <= P_HOLD;
          end
        end
        default: begin
          if (count > 8'h01) begin
            count <= count - 8'h01;
          end else begin
            flash_ce_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            done        <= 1'b1;
            phase       <= P_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: testbench/flash_host_checker.sv */
// checker of the flash host strobe sequencing at its flash pins
// assumes it is bound onto flash_host, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module flash_host_checker #(
  parameter ADDR_W = 19
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0]        flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_we_ctl; !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe; endproperty
  a_we_ctl: assert property (p_we_ctl) else $error("write strobe without select or drive");
  property p_oe_float; !flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n; endproperty
  a_oe_float: assert property (p_oe_float) else $error("host drives data during read");
  property p_idle; flash_ce_n |-> flash_we_n && flash_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe while deselected");
  property p_addr_hold; !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved inside a cycle");
  property p_data_hold; !flash_we_n |-> $stable(flash_dq_out); endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data moved under strobe");
  property p_we_width; $fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe not five cycles");
  property p_we_setup; $fell(flash_we_n) |-> $past(!flash_ce_n); endproperty
  a_we_setup: assert property (p_we_setup) else $error("no select setup before strobe");
  property p_oe_width; $fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 !flash_oe_n [*5] ##1 flash_oe_n; endproperty
  a_oe_width: assert property (p_oe_width) else $error("read strobe not ten cycles");
  property p_ce_release; $rose(flash_we_n) |-> !flash_ce_n [*2] ##[1:2] flash_ce_n; endproperty
  a_ce_release: assert property (p_ce_release) else $error("select hold after write wrong");
endmodule
bind flash_host flash_host_checker #(.ADDR_W(ADDR_W)) u_checker (.pclk(pclk), .presetn(presetn),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

/* File: testbench/nor_flash_model.sv */
// behavioural byte-wide nor flash answering the host strobes
// assumes no clock of its own; the shared data wire is resolved here
`timescale 1ns/1ps
`default_nettype none
module nor_flash_model #(
  parameter [7:0] ID_MAKER  = 8'h3C, // arbitrary value
  parameter [7:0] ID_DEV    = 8'h4D, // arbitrary value
  parameter [7:0] QRY_CODE  = 8'h51,
  parameter [5:0] PROT_SECT = 6'h01
) (
  input  wire logic [18:0] flash_addr,
  input  wire logic [7:0]  flash_dq_out,
  input  wire logic        flash_dq_oe,
  output wire logic [7:0]  dq,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_reset_n,
  input  wire logic        force_fail,
  output wire logic        operation_done_n
);
  reg [7:0]  mem [0:255];
  reg [18:0] a;
  reg [2:0]  st = 3'd0;
  reg [1:0]  mode = 2'd0;
  reg [1:0]  kind = 2'd0;
  reg [3:0]  cnt = 4'd0;
  reg        busy = 1'b0;
  reg        susp = 1'b0;
  reg        tog = 1'b0;
  reg [7:0]  pv = 8'h00;
  reg [7:0]  last = 8'h00;
  reg [7:0]  rv;
  integer    i;
  wire       drive = !flash_oe_n && !flash_ce_n && flash_reset_n;
  // released wire shows the inverse of its last value
  assign dq = flash_dq_oe ? flash_dq_out : drive ? rv : ~last;
  assign operation_done_n = !busy;
  initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
  always @* begin
    if (busy) rv = {kind == 2'd0 ? ~pv[7] : 1'b0, tog, force_fail, 5'h00};
    else if (mode == 2'd1 && flash_addr[1]) rv = {7'h00, flash_addr[18:13] == PROT_SECT};
    else if (mode == 2'd1) rv = flash_addr[0] ? ID_DEV : ID_MAKER;
    else if (mode == 2'd2) rv = QRY_CODE;
    else rv = mem[flash_addr[7:0]];
  end
  always @(negedge flash_we_n) a <= flash_addr;
  always @(posedge flash_oe_n) begin
    last <= rv;
    if (busy) begin
      tog <= ~tog;
      cnt <= cnt - 4'd1;
      if (cnt == 4'd1 && !force_fail) busy <= 1'b0;
    end
  end
  always @(posedge flash_we_n or negedge flash_reset_n) begin
    if (!flash_reset_n) begin
      busy <= 1'b0;
      st <= 3'd0;
      mode <= 2'd0;
      susp <= 1'b0;
    end else if (!flash_ce_n) begin
      last <= flash_dq_out;
      mode <= 2'd0;
      st <= 3'd0;
      if (busy) begin
        if (force_fail && flash_dq_out == 8'hF0) begin
          busy <= 1'b0;
        end else if (kind == 2'd2 && flash_dq_out == 8'hB0) begin
          busy <= 1'b0;
          susp <= 1'b1;
        end
      end else if (st == 3'd6) begin
        mem[a[7:0]] <= mem[a[7:0]] & flash_dq_out;
        pv <= flash_dq_out;
        kind <= 2'd0;
        cnt <= 4'd3;
        busy <= 1'b1;
      end else if (susp && flash_dq_out == 8'h30) begin
        susp <= 1'b0;
        kind <= 2'd2;
        cnt <= 4'd4;
        busy <= 1'b1;
      end else if (st == 3'd0 && a[11:0] == 12'h0AA && flash_dq_out == 8'h98) begin
        mode <= 2'd2;
      end else if (st == 3'd5 && (flash_dq_out == 8'h30 || (flash_dq_out == 8'h10 && a[11:0] == 12'h555))) begin
        kind <= (flash_dq_out == 8'h30) ? 2'd2 : 2'd1;
        cnt <= 4'd6;
        busy <= 1'b1;
        for (i = 0; i < 256; i = i + 1) mem[i] <= 8'hFF;
      end else begin
        case ({st, a[11:0] == 12'h555, a[11:0] == 12'h2AA, flash_dq_out})
          {3'd0, 2'b10, 8'hAA}: st <= 3'd1;
          {3'd1, 2'b01, 8'h55}: st <= 3'd2;
          {3'd2, 2'b10, 8'hA0}: st <= 3'd6;
          {3'd2, 2'b10, 8'h90}: mode <= 2'd1;
          {3'd2, 2'b10, 8'h80}: st <= 3'd3;
          {3'd3, 2'b10, 8'hAA}: st <= 3'd4;
          {3'd4, 2'b01, 8'h55}: st <= 3'd5;
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/flash_host_tb.sv */
// self-checking bench of flash_host driving a behavioural nor flash
// assumes the flash model answers on the host strobes alone
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defs.vh"
module flash_host_tb;
  typedef struct packed {logic [3:0] op; logic [18:0] ad; logic [7:0] wd; logic [7:0] ex; logic ck;} row_t;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg         force_fail = 1'b0;
  reg  [31:0] r;
  reg         e;
  integer     n_mismatch = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  integer     i;
  row_t       rows [0:14];
  wire [31:0] prdata;
  wire [18:0] flash_addr;
  wire [7:0]  flash_dq_out, flash_bus;
  wire        pready, pslverr, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, done_n;
  always #5 pclk = ~pclk;
  flash_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_bus),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .operation_done_n(done_n));
  nor_flash_model u_flash (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .dq(flash_bus), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_n(flash_reset_n), .force_fail(force_fail), .operation_done_n(done_n));
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  task chk_reg(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task run_op(input [3:0] op, input [18:0] ad, input [7:0] wd);
    integer k;
    begin
      apb(`REG_ADDR, 1'b1, {13'h0, ad});
      apb(`REG_WDATA, 1'b1, {24'h0, wd});
      apb(`REG_CMD, 1'b1, {28'h0, op});
      r = 32'h1;
      for (k = 0; k < 4000 && r[`ST_BUSY] !== 1'b0; k = k + 1) apb(`REG_STATUS, 1'b0, 32'h0);
      chk_bit(r[`ST_BUSY], 1'b0);
    end
  endtask
  initial begin
    rows[0] = {`OP_PROGRAM, 19'h00012, 8'h5A, 8'h00, 1'b0};
    rows[1] = {`OP_READ, 19'h00012, 8'h00, 8'h5A, 1'b1};
    rows[2] = {`OP_IDENT, 19'h00000, 8'h00, 8'h3C, 1'b1};
    rows[3] = {`OP_IDENT, 19'h7FF01, 8'h00, 8'h4D, 1'b1};
    rows[4] = {`OP_IDENT, 19'h02002, 8'h00, 8'h01, 1'b1};
    rows[5] = {`OP_IDENT, 19'h04002, 8'h00, 8'h00, 1'b1};
    rows[6] = {`OP_QUERY, 19'h00010, 8'h00, 8'h51, 1'b1};
    rows[7] = {`OP_RESET, 19'h00000, 8'h00, 8'h00, 1'b0};
    rows[8] = {`OP_CHIP_ERASE, 19'h00000, 8'h00, 8'h00, 1'b0};
    rows[9] = {`OP_READ, 19'h00012, 8'h00, 8'hFF, 1'b1};
    rows[10] = {`OP_PROGRAM, 19'h40012, 8'h3C, 8'h00, 1'b0};
    rows[11] = {`OP_SUSPEND, 19'h40000, 8'h00, 8'h00, 1'b0};
    rows[12] = {`OP_RESUME, 19'h40000, 8'h00, 8'h00, 1'b0};
    rows[13] = {`OP_SECT_ERASE, 19'h60000, 8'h00, 8'h00, 1'b0};
    rows[14] = {`OP_READ, 19'h40012, 8'h00, 8'hFF, 1'b1};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 15; i = i + 1) begin
      run_op(rows[i].op, rows[i].ad, rows[i].wd);
      apb(`REG_RDATA, 1'b0, 32'h0);
      if (rows[i].ck) chk_reg(r, {24'h0, rows[i].ex});
    end
    apb(12'h018, 1'b0, 32'h0);
    chk_bit(e, 1'b1);
    apb(`REG_RDATA, 1'b1, 32'hFFFFFFFF);
    apb(`REG_RDATA, 1'b0, 32'h0);
    chk_reg(r, 32'h000000FF);
    apb(`REG_CMD, 1'b1, {28'h0, `OP_SECT_ERASE});
    apb(`REG_CMD, 1'b1, {28'h0, `OP_READ});
    apb(`REG_STATUS, 1'b0, 32'h0);
    chk_reg(r & 32'h11, 32'h11);
    run_op(`OP_READ, 19'h00012, 8'h00);
    apb(`REG_STATUS, 1'b1, 32'h10);
    apb(`REG_STATUS, 1'b0, 32'h0);
    chk_bit(r[`ST_REFUSED], 1'b0);
    force_fail <= 1'b1;
    run_op(`OP_PROGRAM, 19'h00020, 8'h00);
    chk_bit(r[`ST_FAIL], 1'b1);
    chk_bit(done_n, 1'b0);
    run_op(`OP_RESET, 19'h00000, 8'h00);
    force_fail <= 1'b0;
    run_op(`OP_READ, 19'h00020, 8'h00);
    apb(`REG_RDATA, 1'b0, 32'h0);
    chk_reg(r, 32'h00000000);
    apb(`REG_CTRL, 1'b1, 32'h1);
    @(posedge pclk);
    chk_bit(flash_reset_n, 1'b0);
    apb(`REG_CMD, 1'b1, {28'h0, `OP_READ});
    apb(`REG_STATUS, 1'b0, 32'h0);
    chk_bit(r[`ST_REFUSED], 1'b1);
    apb(`REG_CTRL, 1'b1, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_bit(flash_ce_n & flash_we_n & flash_oe_n & ~flash_dq_oe, 1'b1);
    apb(`REG_STATUS, 1'b0, 32'h0);
    chk_reg(r, 32'h00000008);
    final_report;
  end
endmodule
`default_nettype wire
